// ===== design/ptsr_readout.sv
// top: conversion sequencing, result word and serial link of the readout
//
// Functional notes
// - ten-to-ninety variant maps low/high scale to 1638/14746 of 16383.
// - five-to-ninety-five variant maps low/high scale to 819/15563 (gauge), 820/15564 (differential), linear.
// - temperature is 11-bit, 0 at -50 C, 2047 at 150 C.
// - differential variant outputs half range for equal port pressures.
// - count rises as port 1 pressure exceeds port 2.
// - gauge variant: zero gauge is low scale, rated pressure high scale.
// - low-power: measure request wakes sensor, one conversion, results loaded.
// - low-power: sensing powers down after load; host then fetches results.
// - completion interrupt only on non pin-style-L variants.
// - no valid data before start-up delay; then regular update interval, except in low-power, which converts only on a measure request.
`timescale 1ns/1ns
`default_nettype none
module ptsr_readout #(
  parameter int unsigned STARTUP_CYC = ptsr_pkg::STARTUP_CYC,
  parameter int unsigned UPDATE_CYC = ptsr_pkg::UPDATE_CYC
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic variant_b_in,
  input wire logic gauge_in,
  input wire logic low_power_in,
  input wire logic pin_style_l_in,
  input wire logic signed [15:0] level_in,
  input wire logic signed [11:0] temp_dc_in,
  input wire logic link_clk_in,
  input wire logic link_cs_n_in,
  input wire logic link_mosi_in,
  output logic link_miso_out,
  output logic link_miso_oe_out,
  output logic done_int_out,
  output logic done_int_oe_out,
  output logic sense_power_out
);
  // the sequencer counter is 18 bits wide
  if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << 18) || UPDATE_CYC < 1
      || UPDATE_CYC >= (1 << 18)) begin : g_bad_counts
    $error("ptsr_readout: cycle counts out of range");
  end

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_SLEEP = 3'b001,
    ST_CONV = 3'b010,
    ST_LOAD = 3'b011
  } ptsr_state_t;

  // ==========================================================
  // reset release and straps
  logic rst_s1_q;
  logic rst_n_q;
  logic strap_done_q;
  ptsr_pkg::ptsr_straps_t straps_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // straps are caught once, in the first cycle after release
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strap_done_q <= 1'b0;
      straps_q <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      straps_q <= {variant_b_in, gauge_in, low_power_in, pin_style_l_in};
    end
  end

  // ==========================================================
  // link domain
  logic [5:0] rx_cnt_q;
  logic [6:0] rx_sh_q;
  logic [5:0] tx_idx_q;
  logic lk_tog_q;
  logic [7:0] lk_cmd_q;
  ptsr_pkg::ptsr_word_t word_q;

  // cs high clears the frame state; the link clock may stop between frames
  always_ff @(posedge link_clk_in or posedge link_cs_n_in) begin
    if (link_cs_n_in) begin
      rx_cnt_q <= 6'h00;
      rx_sh_q <= 7'h00;
    end else begin
      rx_cnt_q <= (rx_cnt_q == 6'h3f) ? rx_cnt_q : rx_cnt_q + 6'h01;
      rx_sh_q <= {rx_sh_q[5:0], link_mosi_in};
    end
  end

  // eighth bit completes the command byte; toggle tells the core side
  always_ff @(posedge link_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lk_tog_q <= 1'b0;
      lk_cmd_q <= 8'h00;
    end else if (rx_cnt_q == 6'h07) begin
      lk_cmd_q <= {rx_sh_q, link_mosi_in};
      lk_tog_q <= ~lk_tog_q;
    end
  end

  always_ff @(negedge link_clk_in or posedge link_cs_n_in) begin
    if (link_cs_n_in) begin
      tx_idx_q <= 6'h00;
    end else begin
      tx_idx_q <= (tx_idx_q == 6'h3f) ? tx_idx_q : tx_idx_q + 6'h01;
    end
  end

  // word_q is frozen by the core while the frame is open, so it is safe here
  assign link_miso_out = (tx_idx_q < 6'(ptsr_pkg::WORD_BITS))
                       ? word_q[5'(ptsr_pkg::WORD_BITS - 1) - tx_idx_q[4:0]] : 1'b0;
  assign link_miso_oe_out = ~link_cs_n_in;

  // ==========================================================
  // crossings into the core domain
  logic [3:0] tog_s_q;
  logic [2:0] cs_s_q;
  logic busy_q;
  logic cmd_evt;
  logic mr_evt;
  logic fetch_evt;

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tog_s_q <= 4'h0;
      cs_s_q <= 3'h7;
      busy_q <= 1'b0;
    end else begin
      tog_s_q[2:0] <= {tog_s_q[1:0], lk_tog_q};
      if (cmd_evt) begin
        tog_s_q[3] <= tog_s_q[2];
      end
      cs_s_q <= {cs_s_q[1:0], link_cs_n_in};
      if (cs_s_q[1] == cs_s_q[2]) begin
        busy_q <= ~cs_s_q[2];
      end
    end
  end

  // command byte is stable for the whole frame gap, long before the toggle lands
  assign cmd_evt = (tog_s_q[1] == tog_s_q[2]) && (tog_s_q[2] != tog_s_q[3]);
  assign mr_evt = cmd_evt && (lk_cmd_q == ptsr_pkg::CMD_MEASURE);
  assign fetch_evt = cmd_evt && (lk_cmd_q == ptsr_pkg::CMD_FETCH);

  // ==========================================================
  // conversion sequencer
  ptsr_state_t state_q;
  logic [17:0] cnt_q;
  logic [13:0] press_w;
  logic [10:0] temp_w;
  logic [13:0] res_press_q;
  logic [10:0] res_temp_q;
  logic [1:0] status_q;
  logic done_int_q;

  ptsr_scaler u_scaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_q),
    .variant_b_in(straps_q.variant_b),
    .gauge_in(straps_q.gauge),
    .level_in(level_in),
    .temp_dc_in(temp_dc_in),
    .press_out(press_w),
    .temp_out(temp_w)
  );

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_BOOT;
      cnt_q <= 18'h00000;
    end else begin
      unique case (state_q)
        ST_BOOT: begin
          if (cnt_q == 18'(STARTUP_CYC - 1)) begin
            state_q <= ST_LOAD;
            cnt_q <= 18'h00000;
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        ST_SLEEP: begin
          if (mr_evt) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (cnt_q == 18'(UPDATE_CYC - 1)) begin
            state_q <= ST_LOAD;
            cnt_q <= 18'h00000;
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        ST_LOAD: begin
          state_q <= straps_q.low_power ? ST_SLEEP : ST_CONV;
        end
        default: begin
          state_q <= ST_BOOT;
        end
      endcase
    end
  end

  // sensing is unpowered only while asleep in the low-power variant
  assign sense_power_out = !(straps_q.low_power && state_q == ST_SLEEP);

  // load wins over a fetch in the same cycle, so no result is marked read early
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_press_q <= 14'h0000;
      res_temp_q <= 11'h000;
      status_q <= ptsr_pkg::STAT_NOTRDY;
      done_int_q <= 1'b0;
    end else if (state_q == ST_LOAD) begin
      res_press_q <= press_w;
      res_temp_q <= temp_w;
      status_q <= ptsr_pkg::STAT_FRESH;
      done_int_q <= 1'b1;
    end else if (fetch_evt) begin
      if (status_q == ptsr_pkg::STAT_FRESH) begin
        status_q <= ptsr_pkg::STAT_STALE;
      end
      done_int_q <= 1'b0;
    end
  end

  // output word only moves while no frame is open
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word_q <= '{status: ptsr_pkg::STAT_NOTRDY, default: '0};
    end else if (!busy_q) begin
      word_q <= '{status: status_q, pressure: res_press_q, temperature: res_temp_q,
                  pad: 5'h00};
    end
  end

  assign done_int_out = done_int_q && !straps_q.pin_style_l;
  assign done_int_oe_out = strap_done_q && !straps_q.pin_style_l;

  // ==========================================================
  // checks
  boot_notrdy_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (state_q == ST_BOOT) |-> (word_q.status == ptsr_pkg::STAT_NOTRDY))
    else $error("data presented before start-up elapsed");
  lp_wake_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (state_q == ST_SLEEP && mr_evt) |=> (state_q == ST_CONV) && sense_power_out)
    else $error("measure request did not wake sensor");
  load_fresh_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (state_q == ST_LOAD) |=> (status_q == ptsr_pkg::STAT_FRESH)
    && (res_press_q == $past(press_w)))
    else $error("results not loaded");
  lp_sleep_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (state_q == ST_LOAD && straps_q.low_power) |=> !sense_power_out)
    else $error("sensing not powered down after load");
  fetch_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (fetch_evt && state_q != ST_LOAD) |=> !done_int_q)
    else $error("fetch did not clear completion");
  int_omit_a: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    straps_q.pin_style_l |-> !done_int_oe_out && !done_int_out)
    else $error("interrupt driven on pin style L");
  wake_cover_c: cover property (@(posedge clk_in) disable iff (!rst_n_q)
    state_q == ST_SLEEP && mr_evt);
  fetch_cover_c: cover property (@(posedge clk_in) disable iff (!rst_n_q)
    fetch_evt && status_q == ptsr_pkg::STAT_FRESH);
  load_cover_c: cover property (@(posedge clk_in) disable iff (!rst_n_q)
    state_q == ST_LOAD && busy_q);
endmodule
`default_nettype wire

// ===== common/ptsr_pkg.sv
// package: constants and types for the pressure/temperature readout
package ptsr_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned STARTUP_NS = 8400000;
  localparam int unsigned UPDATE_NS = 500000;
  localparam int unsigned STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned UPDATE_CYC = (UPDATE_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // count encodings
  localparam logic [13:0] P_LO_A = 14'h0666;
  localparam logic [13:0] P_HI_A = 14'h399a;
  localparam logic [13:0] P_LO_B = 14'h0333;
  localparam logic [13:0] P_HI_B = 14'h3ccb;
  localparam logic [13:0] P_MID = 14'h2000;
  localparam logic [13:0] P_MAX = 14'h3fff;
  localparam logic [10:0] T_MAX = 11'h7ff;
  localparam int T_OFS_DC = 500;
  localparam int T_SPAN_DC = 2000;
  localparam int LEVEL_FS_LOG2 = 14;
  localparam logic signed [15:0] LEVEL_FS = 16'sh4000;
  // ==========================================================
  // link commands and result status
  localparam logic [7:0] CMD_MEASURE = 8'ha0;
  localparam logic [7:0] CMD_FETCH = 8'h50;
  localparam logic [1:0] STAT_FRESH = 2'h0;
  localparam logic [1:0] STAT_STALE = 2'h2;
  localparam logic [1:0] STAT_NOTRDY = 2'h3;
  localparam int WORD_BITS = 32;
  typedef struct packed {
    logic [1:0] status;
    logic [13:0] pressure;
    logic [10:0] temperature;
    logic [4:0] pad;
  } ptsr_word_t;
  typedef struct packed {
    logic variant_b;
    logic gauge;
    logic low_power;
    logic pin_style_l;
  } ptsr_straps_t;
endpackage

// ===== design/ptsr_scaler.sv
// scaler: raw sensing levels to output counts
`timescale 1ns/1ns
`default_nettype none
module ptsr_scaler (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic variant_b_in,
  input wire logic gauge_in,
  input wire logic signed [15:0] level_in,
  input wire logic signed [11:0] temp_dc_in,
  output logic [13:0] press_out,
  output logic [10:0] temp_out
);
  logic [13:0] press_d;
  logic [10:0] temp_d;
  logic signed [31:0] lo;
  logic signed [31:0] span;
  logic signed [31:0] pv;
  logic signed [31:0] tv;

  // ==========================================================
  // transfer functions
  always_comb begin
    lo = variant_b_in ? 32'(ptsr_pkg::P_LO_B) : 32'(ptsr_pkg::P_LO_A);
    span = (variant_b_in ? 32'(ptsr_pkg::P_HI_B) : 32'(ptsr_pkg::P_HI_A)) - lo;
    if (gauge_in) begin
      // zero gauge at low end, full scale at high end
      pv = lo + ((32'(level_in) * span) >>> ptsr_pkg::LEVEL_FS_LOG2);
    end else begin
      // anchored at mid count so equal ports read exactly half range
      // signed anchor keeps the shift arithmetic for port two excess
      pv = int'(ptsr_pkg::P_MID)
         + ((32'(level_in) * span) >>> (ptsr_pkg::LEVEL_FS_LOG2 + 1));
    end
    // over/under range saturates at the count limits
    if (pv < 0) begin
      press_d = 14'h0000;
    end else if (pv > 32'(ptsr_pkg::P_MAX)) begin
      press_d = ptsr_pkg::P_MAX;
    end else begin
      press_d = pv[13:0];
    end
    tv = ((32'(temp_dc_in) + ptsr_pkg::T_OFS_DC) * int'(ptsr_pkg::T_MAX))
       / ptsr_pkg::T_SPAN_DC;
    if (tv < 0) begin
      temp_d = 11'h000;
    end else if (tv > 32'(ptsr_pkg::T_MAX)) begin
      temp_d = ptsr_pkg::T_MAX;
    end else begin
      temp_d = tv[10:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      press_out <= 14'h0000;
      temp_out <= 11'h000;
    end else begin
      press_out <= press_d;
      temp_out <= temp_d;
    end
  end

  // ==========================================================
  // checks
  gauge_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (gauge_in && level_in == 16'sh0000) |=> press_out == $past(lo[13:0]))
    else $error("gauge zero not at low count");
  span_hi_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (gauge_in && !variant_b_in && level_in == ptsr_pkg::LEVEL_FS)
    |=> press_out == ptsr_pkg::P_HI_A)
    else $error("ten-ninety full scale wrong");
  span_b_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (gauge_in && variant_b_in && level_in == ptsr_pkg::LEVEL_FS)
    |=> press_out == ptsr_pkg::P_HI_B)
    else $error("five-ninetyfive full scale wrong");
  diff_mid_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rst_n_in && !gauge_in && level_in == 16'sh0000) |=> press_out == ptsr_pkg::P_MID)
    else $error("equal ports not at mid count");
  diff_sign_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rst_n_in && !gauge_in && level_in > 16'sh0010) |=> press_out > ptsr_pkg::P_MID)
    else $error("port one excess does not raise count");
  temp_ends_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rst_n_in && temp_dc_in == -12'sd500 |=> temp_out == 11'h000)
    and (rst_n_in && temp_dc_in == 12'sd1500 |=> temp_out == ptsr_pkg::T_MAX))
    else $error("temperature end counts wrong");
endmodule
`default_nettype wire

// ===== tb/ptsr_host_model.sv
// host-side link master model for the readout
`timescale 1ns/1ns
`default_nettype none
module ptsr_host_model (
  input wire logic miso_in,
  input wire logic miso_oe_in,
  output logic link_clk_out,
  output logic link_cs_n_out,
  output logic link_mosi_out
);
  // ==========================================================
  // idle: clock stands low, select high
  initial begin
    link_clk_out = 1'b0;
    link_cs_n_out = 1'b1;
    link_mosi_out = 1'b0;
  end
  // ==========================================================
  // one frame: command byte out, 32-bit word in, msb first
  task automatic frame(input logic [7:0] cmd, output logic [31:0] word);
    #1 link_cs_n_out = 1'b0;
    // odd lead keeps the link edges off the core clock grid
    #2507;
    for (int i = 0; i < 32; i++) begin
      // bits past the command byte toggle so stale data never looks valid
      link_mosi_out = (i < 8) ? cmd[7 - i] : ~link_mosi_out;
      #16 link_clk_out = 1'b1;
      word[31 - i] = (miso_oe_in === 1'b1) ? miso_in : 1'bx;
      #16 link_clk_out = 1'b0;
    end
    #100 link_cs_n_out = 1'b1;
    link_mosi_out = ~link_mosi_out;
    #2000;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_ptsr_readout.sv
// self-checking bench for the readout top
`timescale 1ns/1ns
`default_nettype none
module tb_ptsr_readout;
  localparam int unsigned STARTUP = 200;
  localparam int unsigned UPDATE = 10;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  ptsr_pkg::ptsr_straps_t straps = '0;
  logic signed [15:0] level_in = '0;
  logic signed [11:0] temp_dc_in = '0;
  logic link_clk, link_cs_n, link_mosi, miso, miso_oe, done_int, done_int_oe, sense_power;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_wake = 0;
  ptsr_pkg::ptsr_word_t w;

  always #20 clk_in = ~clk_in;

  ptsr_readout #(.STARTUP_CYC(STARTUP), .UPDATE_CYC(UPDATE)) u_ptsr_readout (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .variant_b_in(straps.variant_b), .gauge_in(straps.gauge),
    .low_power_in(straps.low_power), .pin_style_l_in(straps.pin_style_l),
    .level_in(level_in), .temp_dc_in(temp_dc_in),
    .link_clk_in(link_clk), .link_cs_n_in(link_cs_n), .link_mosi_in(link_mosi),
    .link_miso_out(miso), .link_miso_oe_out(miso_oe),
    .done_int_out(done_int), .done_int_oe_out(done_int_oe), .sense_power_out(sense_power)
  );

  ptsr_host_model u_ptsr_host_model (
    .miso_in(miso), .miso_oe_in(miso_oe),
    .link_clk_out(link_clk), .link_cs_n_out(link_cs_n), .link_mosi_out(link_mosi)
  );

  // ==========================================================
  // watchdog and awake-cycle counter
  always @(posedge clk_in) begin
    cycles++;
    if (sense_power === 1'b1) n_wake++;
    if (cycles == LIMIT) begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // straps must be steady from reset release on
  task automatic restart(input ptsr_pkg::ptsr_straps_t s);
    @(posedge clk_in);
    #1 reset_n_in = 1'b0;
    straps = s;
    repeat (2) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
  endtask

  task automatic settle_fetch(input logic signed [15:0] lv, input logic signed [11:0] t);
    @(posedge clk_in);
    #1 level_in = lv;
    temp_dc_in = t;
    repeat (40) @(posedge clk_in);
    u_ptsr_host_model.frame(ptsr_pkg::CMD_FETCH, w);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_startup();
    restart(4'h0);
    repeat (5) @(posedge clk_in);
    u_ptsr_host_model.frame(ptsr_pkg::CMD_FETCH, w);
    check("early status", 32'(w.status), 32'(ptsr_pkg::STAT_NOTRDY));
    check("int pin", 32'(done_int_oe), 32'h1);
    repeat (STARTUP) @(posedge clk_in);
    settle_fetch(16'sh0, 12'sh0);
    check("ready status", 32'(w.status), 32'(ptsr_pkg::STAT_FRESH));
    check("equal ports", 32'(w.pressure), 32'(ptsr_pkg::P_MID));
  endtask

  task automatic t_diff_a();
    logic signed [15:0] lv[3] = '{16'sh4000, -16'sh4000, 16'sh0};
    logic signed [11:0] tv[3] = '{12'sh5dc, -12'sh1f4, 12'sh0};
    logic [13:0] pe[3] = '{ptsr_pkg::P_HI_A, ptsr_pkg::P_LO_A, ptsr_pkg::P_MID};
    logic [10:0] te[3] = '{ptsr_pkg::T_MAX, 11'h0, 11'h1ff};
    for (int i = 0; i < 3; i++) begin
      settle_fetch(lv[i], tv[i]);
      check("diff a pressure", 32'(w.pressure), 32'(pe[i]));
      check("temperature", 32'(w.temperature), 32'(te[i]));
    end
  endtask

  task automatic t_gauge_a();
    restart(4'h4);
    repeat (STARTUP + 20) @(posedge clk_in);
    settle_fetch(16'sh0, 12'sh0);
    check("gauge a zero", 32'(w.pressure), 32'(ptsr_pkg::P_LO_A));
    settle_fetch(16'sh4000, 12'sh0);
    check("gauge a full", 32'(w.pressure), 32'(ptsr_pkg::P_HI_A));
    settle_fetch(16'sh4800, 12'sh0);
    check("gauge a top", 32'(w.pressure), 32'(ptsr_pkg::P_MAX));
    check("gauge a over", 32'(w.pressure > ptsr_pkg::P_HI_A), 32'h1);
    settle_fetch(-16'sh0800, 12'sh0);
    check("gauge a under", 32'(w.pressure < ptsr_pkg::P_LO_A), 32'h1);
  endtask

  task automatic t_var_b();
    restart(4'hc);
    repeat (STARTUP + 20) @(posedge clk_in);
    settle_fetch(16'sh0, 12'sh0);
    check("gauge b zero", 32'(w.pressure), 32'(ptsr_pkg::P_LO_B));
    settle_fetch(16'sh2000, 12'sh0);
    check("gauge b half", 32'(w.pressure), 32'h1fff);
    settle_fetch(16'sh4000, 12'sh0);
    check("gauge b full", 32'(w.pressure), 32'(ptsr_pkg::P_HI_B));
    restart(4'h8);
    repeat (STARTUP + 20) @(posedge clk_in);
    settle_fetch(16'sh0, 12'sh0);
    check("diff b equal", 32'(w.pressure), 32'(ptsr_pkg::P_MID));
  endtask

  task automatic t_low_power();
    int wake0;
    restart(4'h2);
    repeat (STARTUP + 40) @(posedge clk_in);
    #1;
    check("asleep", 32'(sense_power), 32'h0);
    // fetch the boot result first so the flag starts clear
    settle_fetch(16'sh2000, 12'sh0);
    check("flag cleared", 32'(done_int), 32'h0);
    wake0 = n_wake;
    u_ptsr_host_model.frame(ptsr_pkg::CMD_MEASURE, w);
    repeat (30) @(posedge clk_in);
    #1;
    check("awake span", 32'((n_wake - wake0) inside {[UPDATE:UPDATE + 3]}), 32'h1);
    check("asleep again", 32'(sense_power), 32'h0);
    check("done flag", 32'(done_int), 32'h1);
    u_ptsr_host_model.frame(ptsr_pkg::CMD_FETCH, w);
    check("lp status", 32'(w.status), 32'(ptsr_pkg::STAT_FRESH));
    check("lp pressure", 32'(w.pressure), 32'h2ccd);
    check("flag after fetch", 32'(done_int), 32'h0);
    u_ptsr_host_model.frame(ptsr_pkg::CMD_FETCH, w);
    check("refetch status", 32'(w.status), 32'(ptsr_pkg::STAT_STALE));
  endtask

  task automatic t_pin_l();
    restart(4'h1);
    repeat (STARTUP + 20) @(posedge clk_in);
    #1;
    check("no int pin", 32'(done_int_oe), 32'h0);
    check("no int level", 32'(done_int), 32'h0);
  endtask

  initial begin
    t_startup();
    t_diff_a();
    t_gauge_a();
    t_var_b();
    t_low_power();
    t_pin_l();
    stop_test();
  end
endmodule
`default_nettype wire
